// [src/cat_pkg.sv]
// Package for the counter array timebase and interrupt block.
// Assumes a 32-bit classic Wishbone register bus, byte addressed.
package cat_pkg;

    // -------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_CNT_LOW  = 8'h00;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_MODE     = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_CLEAR    = 8'h14;
    localparam logic [7:0] ADDR_ENABLE   = 8'h18;
    localparam logic [7:0] ADDR_CH_BASE  = 8'h20;
    localparam logic [7:0] ADDR_CH_STEP  = 8'h08;

    // -------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------
    localparam int          MODE_WDT_BIT  = 0;
    localparam int          MODE_TB_LSB   = 1;
    localparam int          MODE_IDLE_BIT = 7;
    localparam int          NUM_CH        = 5;
    localparam int          WDT_CH        = 4;
    localparam logic [7:0]  MODE_RESET    = 8'h01;
    localparam logic [5:0]  ENABLE_RESET  = 6'h00;
    localparam logic [15:0] CH_VAL_RESET  = 16'h0000;

    // -------------------------------------------------------------
    // Timebase codes and divider counts
    // -------------------------------------------------------------
    localparam logic [2:0] TB_DIV12   = 3'h0;
    localparam logic [2:0] TB_DIV4    = 3'h1;
    localparam logic [2:0] TB_TMR0    = 3'h2;
    localparam logic [2:0] TB_EXT_IN  = 3'h3;
    localparam logic [2:0] TB_SYSCLK  = 3'h4;
    localparam logic [2:0] TB_OSC_DIV = 3'h5;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] OSC8_LAST  = 3'h7;

    // -------------------------------------------------------------
    // Channel modes
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        CAT_CH_OFF     = 2'h0,
        CAT_CH_CAPTURE = 2'h1,
        CAT_CH_COMPARE = 2'h2,
        CAT_CH_TOGGLE  = 2'h3
    } cat_ch_mode_t;

    // Array mode register fields
    typedef struct packed {
        logic       idle_suspend;
        logic [2:0] spare;
        logic [2:0] timebase_select;
        logic       watchdog_mode;
    } cat_mode_t;

    // Channel state carried together
    typedef struct packed {
        cat_ch_mode_t mode;
        logic [15:0]  value;
    } cat_ch_t;

endpackage

// [src/cat_timebase_irq.sv]
// Shared 16-bit counter of the counter array, its timebase and its
// interrupt tree, with five simple capture/compare channels.
// Assumes one 100 MHz clock, inputs synchronous to it except ext_osc,
// and a classic Wishbone master on the register side.
`timescale 1ns/1ps

// Operation
// - One 16-bit up-counter seen as separate low and high byte registers.
// - Low byte read snapshots high byte; next high read returns snapshot.
// - Counter reads never disturb counting.
// - Timebase select picks div12, div4, timer0, ext input, clock, osc/8.
// - Ext input falling edges count; source toggles no faster than clock/4.
// - Oscillator divided by 8 is synchronised before advancing counter.
// - Wrap from maximum to zero sets the overflow flag.
// - Overflow enable gates overflow flag onto the array request.
// - Overflow flag is cleared only by software, never on vectoring.
// - Idle suspend clear keeps the array running during CPU idle.
// - Five channels, each with 16-bit register, one line, own mode.
// - Interrupt draws on overflow flag plus five channel event flags.
// - Flags set on their trigger regardless of their enables.
// - Each channel flag has its enable; request is OR of enabled flags.
// - Channel 4 leaves reset in watchdog mode; register access restricted.
module cat_timebase_irq
    import cat_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               cpu_idle,
    input  wire logic               timer0_overflow,
    input  wire logic               external_count_input,
    input  wire logic               ext_osc,
    input  wire logic [NUM_CH-1:0]  channel_io_in,
    output logic      [NUM_CH-1:0]  channel_io_out,
    output logic      [NUM_CH-1:0]  channel_io_oe_n,
    output logic                    watchdog_expire,
    output logic                    array_irq
);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    // Counter, mode and interrupt registers
    logic [15:0]       counter_array;
    logic [7:0]        high_snapshot;
    cat_mode_t         array_mode_register;
    logic [NUM_CH:0]   irq_status;
    logic [NUM_CH:0]   irq_enable;
    cat_ch_t           ch [NUM_CH];

    // Timebase prescalers, sampled inputs and the shared tick
    logic [3:0]        div12_cnt;
    logic              eci_q;
    logic [2:0]        osc_sync;
    logic [2:0]        osc_div;
    logic              tick;
    logic              run;
    logic              advance;

    // Bus decode
    logic              cnt_wr_low;
    logic              cnt_wr_high;
    logic              wr;
    logic              rd;
    logic              mode_locked;

    // Channel decode and events
    logic [NUM_CH-1:0] ch_in_q;
    logic [NUM_CH-1:0] ch_event;
    logic [NUM_CH-1:0] ch_wr;
    logic [NUM_CH-1:0] ch_mode_wr;

    // Counter step and interrupt flag terms
    logic [15:0]       next_counter;
    logic              wrap;
    logic [NUM_CH:0]   flag_set;
    logic [NUM_CH:0]   flag_clr;

    // Channel register decode: value at base + 8n, mode at base + 8n + 4
    // Shared by the write strobes and the read mux
    function automatic logic ch_hit(input logic [7:0] adr, input int n,
                                    input logic hi);
        logic [7:0] a;
        a = ADDR_CH_BASE + 8'(n) * ADDR_CH_STEP + (hi ? 8'h04 : 8'h00);
        return adr == a;
    endfunction

    // -------------------------------------------------------------
    // Bus strobes
    // -------------------------------------------------------------
    // Request taken once, acknowledged in the next cycle
    // Writes need byte lane 0; every register sits in the low lanes
    assign wr          = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                         && wb_sel_i[0];
    assign rd          = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    assign mode_locked = array_mode_register.watchdog_mode;
    // Counter writes refused while the watchdog mode holds the array
    assign cnt_wr_low  = wr && !mode_locked && wb_adr_i == ADDR_CNT_LOW;
    assign cnt_wr_high = wr && !mode_locked && wb_adr_i == ADDR_CNT_HIGH;

    // Ack pulse, one cycle after the request appears
    // A request held through its ack is not taken twice
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // -------------------------------------------------------------
    // Timebase
    // -------------------------------------------------------------
    // Divide-by-12 prescaler; divide-by-4 taps its low bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div12_cnt <= 4'h0;
        end else if (div12_cnt == DIV12_LAST) begin
            div12_cnt <= 4'h0;
        end else begin
            div12_cnt <= div12_cnt + 4'h1;
        end
    end

    // External count input sampled for edge detection
    // Reset low, so a pin idling high gives no edge after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eci_q <= 1'b0;
        end else begin
            eci_q <= external_count_input;
        end
    end

    // Oscillator synchroniser; edges counted only past stage two
    // Stage three only delays stage two for the edge detector
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_sync <= 3'h0;
            osc_div  <= 3'h0;
        end else begin
            osc_sync <= {osc_sync[1:0], ext_osc};
            if (osc_sync[1] && !osc_sync[2]) begin
                osc_div <= osc_div + 3'h1;
            end
        end
    end

    // Source selection; reserved codes give no tick
    // Ext input tick compares its sampled copy with the live pin; osc tick uses synchroniser stages
    always_comb begin
        case (array_mode_register.timebase_select)
            TB_DIV12:   tick = div12_cnt == DIV12_LAST;
            TB_DIV4:    tick = div12_cnt[1:0] == DIV4_LAST;
            TB_TMR0:    tick = timer0_overflow;
            TB_EXT_IN:  tick = eci_q && !external_count_input;
            TB_SYSCLK:  tick = 1'b1;
            TB_OSC_DIV: tick = osc_sync[1] && !osc_sync[2]
                               && osc_div == OSC8_LAST;
            default:    tick = 1'b0;
        endcase
    end

    // Idle stops the array only when idle suspend is set
    assign run = !(cpu_idle && array_mode_register.idle_suspend);

    // Shared advance strobe for counter, compares and watchdog
    assign advance = tick && run;

    // -------------------------------------------------------------
    // Counter and snapshot
    // -------------------------------------------------------------
    assign next_counter = counter_array + 16'h0001;

    // A byte write wins the cycle, so it never counts as a wrap
    assign wrap = advance && !cnt_wr_low && !cnt_wr_high
                  && counter_array == 16'hffff;

    // Counter runs regardless of reads; software writes load a byte
    // A byte write wins over a tick in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_array <= 16'h0000;
        end else if (cnt_wr_low) begin
            counter_array[7:0] <= wb_dat_i[7:0];
        end else if (cnt_wr_high) begin
            counter_array[15:8] <= wb_dat_i[7:0];
        end else if (advance) begin
            counter_array <= next_counter;
        end
    end

    // Low byte read captures the high byte for the next high read
    // Taken at the low byte's read edge, so both halves agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_snapshot <= 8'h00;
        end else if (rd && wb_adr_i == ADDR_CNT_LOW) begin
            high_snapshot <= counter_array[15:8];
        end
    end

    // -------------------------------------------------------------
    // Mode register
    // -------------------------------------------------------------
    // Watchdog mode set at reset; while set only the mode bit is writable
    // Software clears watchdog mode first to unlock the other fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            array_mode_register <= cat_mode_t'(MODE_RESET);
        end else if (wr && wb_adr_i == ADDR_MODE) begin
            array_mode_register.watchdog_mode <= wb_dat_i[MODE_WDT_BIT];
            if (!mode_locked) begin
                array_mode_register.timebase_select <=
                    wb_dat_i[MODE_TB_LSB +: 3];
                array_mode_register.idle_suspend <= wb_dat_i[MODE_IDLE_BIT];
            end
        end
    end

    // -------------------------------------------------------------
    // Channels
    // -------------------------------------------------------------
    // Registered copy of the channel lines for edge detection
    // Reset low, so a line idling high gives no capture after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch_in_q <= '0;
        end else begin
            ch_in_q <= channel_io_in;
        end
    end

    // Per-channel registers, modes and events
    for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
        // Watchdog channel refuses writes while watchdog mode holds
        assign ch_wr[n]      = wr && ch_hit(wb_adr_i, n, 1'b0)
                               && !(n == WDT_CH && mode_locked);
        assign ch_mode_wr[n] = wr && ch_hit(wb_adr_i, n, 1'b1)
                               && !(n == WDT_CH && mode_locked);

        // Event per the channel's own mode
        always_comb begin
            case (ch[n].mode)
                CAT_CH_CAPTURE: ch_event[n] = ch_in_q[n] && !channel_io_in[n];
                CAT_CH_COMPARE: ch_event[n] = advance
                                    && counter_array == ch[n].value;
                CAT_CH_TOGGLE:  ch_event[n] = advance
                                    && counter_array == ch[n].value;
                default:        ch_event[n] = 1'b0;
            endcase
        end

        // Value and mode; capture loads the counter
        // A software write wins over a capture in the same cycle
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ch[n] <= {CAT_CH_OFF, CH_VAL_RESET};
            end else begin
                if (ch_mode_wr[n]) begin
                    ch[n].mode <= cat_ch_mode_t'(wb_dat_i[1:0]);
                end
                if (ch_wr[n]) begin
                    ch[n].value <= wb_dat_i[15:0];
                end else if (ch_event[n] && ch[n].mode == CAT_CH_CAPTURE) begin
                    ch[n].value <= counter_array;
                end
            end
        end

        // Line driven only in toggle mode; toggles on each match
        // Output enable low while the line is driven
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                channel_io_out[n]  <= 1'b0;
                channel_io_oe_n[n] <= 1'b1;
            end else begin
                channel_io_oe_n[n] <= ch[n].mode != CAT_CH_TOGGLE;
                if (ch_event[n] && ch[n].mode == CAT_CH_TOGGLE) begin
                    channel_io_out[n] <= !channel_io_out[n];
                end
            end
        end
    end

    // Watchdog expiry when channel 4 matches in watchdog mode
    // High byte match, so expiry repeats for each tick of that byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_expire <= 1'b0;
        end else begin
            watchdog_expire <= mode_locked && advance
                               && counter_array[15:8] == ch[WDT_CH].value[15:8];
        end
    end

    // -------------------------------------------------------------
    // Interrupt flags
    // -------------------------------------------------------------
    // Flag sources: overflow on bit 0, channel n on bit n + 1
    assign flag_set = {ch_event, wrap};

    // Write-one clear; no hardware path clears a flag
    assign flag_clr = (wr && wb_adr_i == ADDR_CLEAR) ? wb_dat_i[NUM_CH:0]
                                                     : '0;

    // Sticky flags: set always, set beats write-one clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~flag_clr) | flag_set;
        end
    end

    // Enable register: bit 0 overflow, bits 5:1 channels
    // Flags keep setting while their enables are clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable <= ENABLE_RESET;
        end else if (wr && wb_adr_i == ADDR_ENABLE) begin
            irq_enable <= wb_dat_i[NUM_CH:0];
        end
    end

    // Level request, OR of every enabled flag
    // CPU side gates it further with its own enables
    assign array_irq = |(irq_status & irq_enable);

    // -------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------
    // Registered read mux; unmapped and write-only read zero
    // Latched at the request edge, so data stands with ack
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                ADDR_CNT_LOW:  wb_dat_o[7:0] <= counter_array[7:0];
                ADDR_CNT_HIGH: wb_dat_o[7:0] <= high_snapshot;
                ADDR_MODE:     wb_dat_o[7:0] <= array_mode_register;
                ADDR_STATUS:   wb_dat_o[NUM_CH:0] <= irq_status;
                ADDR_ENABLE:   wb_dat_o[NUM_CH:0] <= irq_enable;
                default: begin
                    for (int n = 0; n < NUM_CH; n++) begin
                        if (ch_hit(wb_adr_i, n, 1'b0)) begin
                            wb_dat_o[15:0] <= ch[n].value;
                        end
                        if (ch_hit(wb_adr_i, n, 1'b1)) begin
                            wb_dat_o[1:0] <= ch[n].mode;
                        end
                    end
                end
            endcase
        end
    end

endmodule // cat_timebase_irq

// [sim/cat_timebase_irq_props.sv]
// Checker for the counter array block: bus timing, read data and irq.
// Assumes the block's own ports only; attached by bind at the foot.
`timescale 1ns/1ps

module cat_timebase_irq_props
    import cat_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        array_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // --------------------------------------------------------------
    // Bus answer
    // --------------------------------------------------------------
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved outside ack");

    // --------------------------------------------------------------
    // Read data shape
    // --------------------------------------------------------------
    unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h0c |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    byte_width_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == ADDR_CNT_LOW |=> wb_dat_o[31:8] == 24'h0)
        else $error("counter byte wider than eight bits");
    status_width_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == ADDR_STATUS |=> wb_dat_o[31:6] == 26'h0)
        else $error("status wider than six flags");

    // --------------------------------------------------------------
    // Interrupt falls only after a software write
    // --------------------------------------------------------------
    irq_fall_cause_a: assert property ($fell(array_irq) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("irq dropped without software write");
endmodule // cat_timebase_irq_props

bind cat_timebase_irq cat_timebase_irq_props cat_timebase_irq_props_i (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .array_irq(array_irq));

// [sim/cat_timebase_irq_tb.sv]
// Testbench for the counter array block: register sequences over Wishbone.
// Assumes the checker is bound separately; channel lines driven here.
`timescale 1ns/1ps

module cat_timebase_irq_tb;
    import cat_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cpu_idle = 1'b0;
    logic        timer0_overflow = 1'b0;
    logic        external_count_input = 1'b1;
    logic        ext_osc = 1'b0;
    logic [2:0]  tcnt = 3'h0;
    logic        array_irq;
    logic [4:0]  ch_in = 5'h00;
    logic [4:0]  io_out;
    logic [4:0]  io_oe_n;
    logic        wd_expire;
    logic        wd_seen = 1'b0;
    logic [1:0]  cpu_irq_en = 2'b00; // CPU side: global and array enables
    logic [31:0] q;
    logic [15:0] cnt;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          dv[6] = '{12, 4, 8, 8, 1, 24};

    cat_timebase_irq cat_timebase_irq_i (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_idle(cpu_idle),
        .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
        .ext_osc(ext_osc), .channel_io_in(ch_in), .channel_io_out(io_out),
        .channel_io_oe_n(io_oe_n), .watchdog_expire(wd_expire), .array_irq(array_irq));

    // --------------------------------------------------------------
    // Clocks, tick sources and timeout
    // --------------------------------------------------------------
    always #5 clk = ~clk;
    always #15 ext_osc <= #2 ~ext_osc; // Edges kept off the clock edges
    // Timer0 pulse and ext input falling edge every 8 cycles
    always @(posedge clk) begin
        tcnt <= tcnt + 3'h1;
        timer0_overflow <= (tcnt == 3'h7);
        external_count_input <= tcnt[2];
        cycles <= cycles + 1;
        if (wd_expire) wd_seen <= 1'b1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Count with a chosen mode for 240 cycles, then freeze and read
    task automatic run(input logic [7:0] md);
        logic [7:0] lo;
        wr(ADDR_MODE, 32'h0e);
        wr(ADDR_CNT_LOW, 32'h0);
        wr(ADDR_CNT_HIGH, 32'h0);
        wr(ADDR_MODE, {24'h0, md});
        repeat (237) @(posedge clk);
        wr(ADDR_MODE, 32'h0e);
        xfer(1'b0, ADDR_CNT_LOW, 32'h0);
        lo = q[7:0];
        xfer(1'b0, ADDR_CNT_HIGH, 32'h0);
        cnt = {q[7:0], lo};
    endtask
    task automatic near(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if ((^got) === 1'bx || got > exp + 16'h1 || got + 16'h1 < exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdchk(ADDR_MODE, 32'h01);
        wr(ADDR_MODE, 32'h09);
        rdchk(ADDR_MODE, 32'h01);
        rdchk(8'h0c, 32'h0);
        repeat (12) @(posedge clk);
        wr(ADDR_MODE, 32'h00);
        chk({31'h0, wd_seen}, 32'h1);
        rdchk(ADDR_MODE, 32'h00);
        // Every timebase code, reserved ones frozen
        for (int c = 0; c < 8; c++) begin
            run(8'(c * 2));
            if (c < 6) near(cnt, 16'(240 / dv[c]));
            else chk({16'h0, cnt}, 32'h0);
        end
        // Idle suspend holds, clear keeps running
        cpu_idle <= 1'b1;
        run(8'h88);
        chk({16'h0, cnt}, 32'h0);
        run(8'h08);
        near(cnt, 16'd240);
        cpu_idle <= 1'b0;
        run(8'h88);
        near(cnt, 16'd240);
        // Snapshot of high byte, counting undisturbed
        wr(ADDR_CNT_LOW, 32'h0);
        wr(ADDR_MODE, 32'h08);
        rdchk(ADDR_CNT_LOW, 32'h02);
        repeat (300) @(posedge clk);
        rdchk(ADDR_CNT_HIGH, 32'h00);
        xfer(1'b0, ADDR_CNT_LOW, 32'h0);
        rdchk(ADDR_CNT_HIGH, 32'h01);
        // Overflow flag and its enable
        wr(ADDR_MODE, 32'h0e);
        wr(ADDR_CNT_LOW, 32'hf0);
        wr(ADDR_CNT_HIGH, 32'hff);
        wr(ADDR_ENABLE, 32'h01);
        chk({31'h0, array_irq}, 32'h0);
        wr(ADDR_MODE, 32'h08);
        repeat (40) @(posedge clk);
        wr(ADDR_MODE, 32'h0e);
        rdchk(ADDR_STATUS, 32'h01);
        chk({31'h0, array_irq}, 32'h1);
        chk({31'h0, array_irq && cpu_irq_en == 2'b11}, 32'h0);
        cpu_irq_en <= 2'b11;
        @(posedge clk);
        chk({31'h0, array_irq && cpu_irq_en == 2'b11}, 32'h1);
        wr(ADDR_ENABLE, 32'h00);
        chk({31'h0, array_irq}, 32'h0);
        rdchk(ADDR_STATUS, 32'h01);
        wr(ADDR_CLEAR, 32'h01);
        rdchk(ADDR_STATUS, 32'h00);
        // Channel compare flags, channel 2 left off
        wr(ADDR_CNT_LOW, 32'h0);
        wr(ADDR_CNT_HIGH, 32'h0);
        for (int n = 0; n < NUM_CH; n++) begin
            wr(ADDR_CH_BASE + 8'(n * 8), 32'h0008);
            wr(ADDR_CH_BASE + 8'(n * 8 + 4), (n == 2) ? 32'h0 : 32'h2);
        end
        wr(ADDR_MODE, 32'h08);
        repeat (30) @(posedge clk);
        wr(ADDR_MODE, 32'h0e);
        for (int n = 0; n < NUM_CH; n++) rdchk(ADDR_CH_BASE + 8'(n * 8), 32'h0008);
        rdchk(ADDR_STATUS, 32'h36);
        chk({31'h0, array_irq}, 32'h0);
        for (int n = 0; n < NUM_CH; n++) begin
            wr(ADDR_ENABLE, 32'h1 << (n + 1));
            chk({31'h0, array_irq}, (n == 2) ? 32'h0 : 32'h1);
        end
        wr(ADDR_CLEAR, 32'h3f);
        chk({31'h0, array_irq}, 32'h0);
        rdchk(ADDR_STATUS, 32'h00);
        // Toggle line on a match, capture on a falling channel edge
        wr(ADDR_CNT_LOW, 32'h0);
        wr(ADDR_CH_BASE + 8'h04, 32'h3);
        wr(ADDR_CH_BASE + 8'h0c, 32'h1);
        wr(ADDR_MODE, 32'h08);
        repeat (30) @(posedge clk);
        wr(ADDR_MODE, 32'h0e);
        chk({30'h0, io_oe_n[0], io_out[0]}, 32'h1);
        ch_in <= 5'h02;
        repeat (3) @(posedge clk);
        ch_in <= 5'h00;
        repeat (3) @(posedge clk);
        rdchk(ADDR_CH_BASE + 8'h08, 32'h21);
        rdchk(ADDR_STATUS, 32'h36);
        report_and_stop();
    end
endmodule // cat_timebase_irq_tb
